// *** shared/serial_port_pkg.sv ***
// Constants, types and helpers shared by the serial control port design
package serial_port_pkg;

    // ========================================================================
    // Geometry
    localparam int ADDR_WIDTH = 10;
    localparam int INSTR_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam int REG_COUNT = 32'h0000_0233;

    // ========================================================================
    // Register addresses and fields
    localparam logic [ADDR_WIDTH-1:0] CONFIG_ADDR = 10'h000;
    localparam logic [ADDR_WIDTH-1:0] READSEL_ADDR = 10'h004;
    localparam logic [ADDR_WIDTH-1:0] UPDATE_ADDR = 10'h232;
    localparam logic [ADDR_WIDTH-1:0] TOP_ADDR = 10'h232;
    localparam logic [BYTE_BITS-1:0] CONFIG_RESET = 8'h18;
    localparam int SDO_SEL_BIT = 0;
    localparam int LSB_FIRST_BIT = 1;
    localparam int READSEL_BIT = 0;
    localparam int UPDATE_BIT = 0;

    // ========================================================================
    // Instruction word layout and counts
    localparam int INSTR_RW_BIT = 15;
    localparam int LEN_MSB = 14;
    localparam int LEN_LSB = 13;
    localparam int ADDR_MSB = ADDR_WIDTH - 1;
    localparam logic [1:0] LEN_STREAM = 2'h3;
    localparam logic [3:0] LAST_INSTR_COUNT = 4'hF;
    localparam logic [2:0] LAST_BIT_INDEX = 3'h7;

    typedef enum logic [1:0] {PH_INSTR, PH_DATA, PH_DONE} phase_type;

    // ========================================================================
    // Helpers
    function automatic logic [ADDR_WIDTH-1:0] step_address(
        input logic [ADDR_WIDTH-1:0] addr,
        input logic lsb_first);
        if (lsb_first) begin
            step_address = (addr == TOP_ADDR) ? CONFIG_ADDR : addr + 10'h001;
        end else begin
            step_address = (addr == CONFIG_ADDR) ? TOP_ADDR : addr - 10'h001;
        end
    endfunction

    function automatic logic [1:0] len_to_bytes(input logic [1:0] code);
        len_to_bytes = code + 2'h1;
    endfunction

endpackage

// *** rtl/serial_control_port.sv ***
// Serial register-access port with shadow and active register banks
//
// Summary of operation
// - Host bits taken on rising serial clock, readback launched on falling.
// - Output-select bit sends readback to the dedicated pin only.
// - Both data pins are released whenever chip select is high.
// - Fixed-length frames may stall at byte boundaries and resume afterwards.
// - A stalled frame is abandoned by finishing it or a short partial byte.
// - Chip select rising off a byte boundary discards the frame and resets.
// - Streaming moves bytes up to the top register address, stepping the address every byte.
// - Every frame starts with a sixteen-bit instruction word.
// - Instruction: read flag, two-bit length code, thirteen-bit address.
// - Length code 00,01,10 means one, two, three bytes; 11 streams.
// - Writes fill the shadow bank; update bit copies all of it at once.
// - Reads shift out eight bits per byte; streams run until the top register address.
// - Streaming visits every address, reserved ones included.
// - Readback-select bit chooses the active bank or the shadow bank.
// - Only the long instruction form exists; its bits reset to 11b.
// - Top three address bits are zero; ten low bits are decoded.
// - Most-significant-first transfers decrement the address each byte.
// - In bidirectional mode the shared pin turns around for read data.
// - Chip select after the last write byte ends; earlier at a byte boundary only stalls.
// - LSB-first order shifts bits LSB first and increments the address.
// - Streaming stops after the byte at the top register address.
// - Bit-order selection takes effect at once, without an update.
module serial_control_port
    import serial_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    output logic dedicated_readback_pin,
    output logic readback_oe,
    output logic frame_active,
    output logic config_update,
    output logic lsb_first_mode,
    output logic separate_readback_mode
);

    // ========================================================================
    // Link-side state, clocked by the serial clock
    typedef struct packed {
        phase_type phase;
        logic [3:0] bit_count;
        logic [INSTR_BITS-1:0] instr;
        logic [BYTE_BITS-1:0] data;
        logic [ADDR_WIDTH-1:0] addr;
        logic rw;
        logic [1:0] len_code;
        logic stream;
        logic [1:0] bytes_left;
        logic [BYTE_BITS-1:0] cfg0;
        logic readback_active;
        logic rise_copy;
        logic update_tgl;
    } link_state_type;

    typedef struct packed {
        logic sdio_out;
        logic sdio_oe;
        logic rb_out;
        logic rb_oe;
    } pin_state_type;

    typedef struct packed {
        logic cs_meta;
        logic cs_sync;
        logic tgl_meta;
        logic tgl_sync;
        logic tgl_prev;
        logic lsb_meta;
        logic lsb_sync;
        logic sdo_meta;
        logic sdo_sync;
        logic frame_active;
        logic config_update;
    } sys_state_type;

    localparam link_state_type LINK_RESET = '{
        phase: PH_INSTR,
        cfg0: CONFIG_RESET,
        default: '0
    };

    link_state_type st;
    link_state_type next_st;
    pin_state_type pin;
    pin_state_type next_pin;
    sys_state_type sys;
    sys_state_type next_sys;

    logic cs_rise_tgl;
    logic rise_seen;
    logic pin_clear;
    logic wr_en;
    logic do_update;
    logic [ADDR_WIDTH-1:0] wr_addr;
    logic [BYTE_BITS-1:0] wr_data;
    logic [BYTE_BITS-1:0] rd_byte;
    logic [BYTE_BITS-1:0] shadow_mem [REG_COUNT];
    logic [BYTE_BITS-1:0] active_mem [REG_COUNT];

    // ========================================================================
    // Frame end marker
    // The serial clock is still while chip select is high, so the rise is
    // recorded by chip select itself. The toggle settles a full setup time
    // before the next rising serial edge, which then compares it.
    always_ff @(posedge cs_n or posedge rst) begin
        if (rst) begin
            cs_rise_tgl <= 1'b0;
        end else begin
            cs_rise_tgl <= ~cs_rise_tgl;
        end
    end

    // ========================================================================
    // Instruction and data sequencing
    always_comb begin
        logic lsb;
        logic [BYTE_BITS-1:0] byte_in;
        lsb = 1'b0;
        byte_in = '0;
        next_st = st;
        wr_en = 1'b0;
        do_update = 1'b0;
        wr_addr = st.addr;
        wr_data = '0;
        rise_seen = (cs_rise_tgl != st.rise_copy);
        next_st.rise_copy = cs_rise_tgl;
        // Off-boundary release flushes the frame; stall at boundary keeps it
        if (rise_seen && (st.bit_count[2:0] != 3'h0)) begin
            next_st.phase = PH_INSTR;
            next_st.bit_count = '0;
        end
        if (rise_seen && st.phase == PH_DONE) begin
            next_st.phase = PH_INSTR;
            next_st.bit_count = '0;
        end
        lsb = st.cfg0[LSB_FIRST_BIT];
        unique case (next_st.phase)
            PH_INSTR: begin
                next_st.instr = lsb ? {sdio_in, next_st.instr[15:1]}
                                    : {next_st.instr[14:0], sdio_in};
                if (next_st.bit_count == LAST_INSTR_COUNT) begin
                    next_st.rw = next_st.instr[INSTR_RW_BIT];
                    next_st.len_code = next_st.instr[LEN_MSB:LEN_LSB];
                    next_st.addr = next_st.instr[ADDR_MSB:0];
                    next_st.stream = (next_st.len_code == LEN_STREAM);
                    next_st.bytes_left = len_to_bytes(next_st.len_code);
                    next_st.phase = PH_DATA;
                    next_st.bit_count = '0;
                end else begin
                    next_st.bit_count = next_st.bit_count + 4'h1;
                end
            end
            PH_DATA: begin
                byte_in = lsb ? {sdio_in, next_st.data[7:1]}
                              : {next_st.data[6:0], sdio_in};
                next_st.data = byte_in;
                if (next_st.bit_count[2:0] == LAST_BIT_INDEX) begin
                    next_st.bit_count = '0;
                    if (!next_st.rw && next_st.addr <= TOP_ADDR) begin
                        wr_en = 1'b1;
                        wr_data = byte_in;
                        if (next_st.addr == CONFIG_ADDR) begin
                            next_st.cfg0 = byte_in;
                        end
                        if (next_st.addr == READSEL_ADDR) begin
                            next_st.readback_active = byte_in[READSEL_BIT];
                        end
                        if (next_st.addr == UPDATE_ADDR
                            && byte_in[UPDATE_BIT]) begin
                            do_update = 1'b1;
                            next_st.update_tgl = ~next_st.update_tgl;
                        end
                    end
                    // Reserved addresses are never skipped
                    next_st.addr = step_address(next_st.addr, lsb);
                    if (next_st.stream) begin
                        if (st.addr == TOP_ADDR) begin
                            next_st.phase = PH_DONE;
                        end
                    end else if (next_st.bytes_left == 2'h1) begin
                        next_st.phase = PH_DONE;
                    end else begin
                        next_st.bytes_left = next_st.bytes_left - 2'h1;
                    end
                end else begin
                    next_st.bit_count = next_st.bit_count + 4'h1;
                end
            end
            PH_DONE: begin
                next_st.bit_count = '0;
            end
        endcase
    end

    // Host bits are taken on the rising serial edge
    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            st <= LINK_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ========================================================================
    // Register banks
    // The update copies the whole bank in one edge: a wide mux traded for
    // a single instant at which every buffered change becomes active.
    always_ff @(posedge sclk) begin
        if (wr_en) begin
            if (wr_addr == UPDATE_ADDR) begin
                shadow_mem[wr_addr] <= {wr_data[7:1], 1'b0};
            end else begin
                shadow_mem[wr_addr] <= wr_data;
            end
        end
        if (do_update) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                active_mem[i] <= shadow_mem[i];
            end
        end
    end

    always_comb begin
        if (st.addr > TOP_ADDR) begin
            rd_byte = '0;
        end else if (st.addr == CONFIG_ADDR) begin
            rd_byte = st.cfg0;
        end else if (st.readback_active) begin
            rd_byte = active_mem[st.addr];
        end else begin
            rd_byte = shadow_mem[st.addr];
        end
    end

    // ========================================================================
    // Readback pins, launched on the falling serial edge
    always_comb begin
        logic drive;
        logic bit_out;
        logic [2:0] idx;
        drive = (st.phase == PH_DATA) && st.rw;
        idx = st.cfg0[LSB_FIRST_BIT] ? st.bit_count[2:0]
                                     : LAST_BIT_INDEX - st.bit_count[2:0];
        bit_out = rd_byte[idx];
        next_pin.sdio_out = drive && !st.cfg0[SDO_SEL_BIT] && bit_out;
        next_pin.sdio_oe = drive && !st.cfg0[SDO_SEL_BIT];
        next_pin.rb_out = drive && st.cfg0[SDO_SEL_BIT] && bit_out;
        next_pin.rb_oe = drive && st.cfg0[SDO_SEL_BIT];
    end

    assign pin_clear = cs_n | rst;

    // Chip select high releases both pins at once, no serial edge needed
    always_ff @(negedge sclk or posedge pin_clear) begin
        if (pin_clear) begin
            pin <= '0;
        end else begin
            pin <= next_pin;
        end
    end

    // ========================================================================
    // Status toward the reference clock domain
    always_comb begin
        next_sys = sys;
        next_sys.cs_meta = cs_n;
        next_sys.cs_sync = sys.cs_meta;
        next_sys.tgl_meta = st.update_tgl;
        next_sys.tgl_sync = sys.tgl_meta;
        next_sys.tgl_prev = sys.tgl_sync;
        next_sys.lsb_meta = st.cfg0[LSB_FIRST_BIT];
        next_sys.lsb_sync = sys.lsb_meta;
        next_sys.sdo_meta = st.cfg0[SDO_SEL_BIT];
        next_sys.sdo_sync = sys.sdo_meta;
        next_sys.frame_active = !sys.cs_sync;
        next_sys.config_update = sys.tgl_sync ^ sys.tgl_prev;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sys <= '0;
        end else begin
            sys <= next_sys;
        end
    end

    assign sdio_out = pin.sdio_out;
    assign sdio_oe = pin.sdio_oe;
    assign dedicated_readback_pin = pin.rb_out;
    assign readback_oe = pin.rb_oe;
    assign frame_active = sys.frame_active;
    assign config_update = sys.config_update;
    assign lsb_first_mode = sys.lsb_sync;
    assign separate_readback_mode = sys.sdo_sync;

    // ========================================================================
    // Checks
    chk_instr_length: assert property (
        @(posedge sclk) disable iff (rst)
        (st.phase == PH_INSTR && st.bit_count == LAST_INSTR_COUNT
            && !rise_seen) |=> (st.phase == PH_DATA && st.bit_count == 4'h0))
        else $error("instruction did not end after sixteen bits");

    chk_length_decode: assert property (
        @(posedge sclk) disable iff (rst)
        (st.phase == PH_INSTR ##1 st.phase == PH_DATA)
        |-> (st.stream == (st.len_code == LEN_STREAM))
            && (st.stream || st.bytes_left == st.len_code + 2'h1))
        else $error("length code decoded wrongly");

    chk_flush_reset: assert property (
        @(posedge sclk) disable iff (rst)
        (rise_seen && st.bit_count[2:0] != 3'h0)
        |=> (st.phase == PH_INSTR && st.bit_count == 4'h1))
        else $error("off-boundary release did not restart the frame");

    chk_stall_keep: assert property (
        @(posedge sclk) disable iff (rst)
        (rise_seen && st.bit_count == 4'h0 && st.phase == PH_DATA)
        |=> (st.phase == PH_DATA && st.addr == $past(st.addr)
            && st.bit_count == 4'h1))
        else $error("stall at a byte boundary lost the frame");

    chk_addr_step: assert property (
        @(posedge sclk) disable iff (rst)
        (st.phase == PH_DATA && st.bit_count[2:0] == LAST_BIT_INDEX
            && !rise_seen)
        |=> st.addr == step_address($past(st.addr),
                                    $past(st.cfg0[LSB_FIRST_BIT])))
        else $error("address not stepped after a byte");

    chk_stream_stop: assert property (
        @(posedge sclk) disable iff (rst)
        (st.phase == PH_DATA && st.stream && st.addr == TOP_ADDR
            && st.bit_count[2:0] == LAST_BIT_INDEX && !rise_seen)
        |=> st.phase == PH_DONE)
        else $error("stream did not stop at the top address");

    chk_update_copy: assert property (
        @(posedge sclk) disable iff (rst)
        do_update
        |=> (active_mem[READSEL_ADDR] == $past(shadow_mem[READSEL_ADDR])
            && shadow_mem[UPDATE_ADDR][UPDATE_BIT] == 1'b0))
        else $error("update did not copy the shadow bank");

    chk_pin_select: assert property (
        @(posedge sclk) disable iff (rst)
        (sdio_oe |-> !st.cfg0[SDO_SEL_BIT])
        and (readback_oe |-> st.cfg0[SDO_SEL_BIT]))
        else $error("readback on the wrong pin");
    chk_pins_released: assert property (
        @(posedge ref_clk) disable iff (rst)
        cs_n |-> (!sdio_oe && !readback_oe))
        else $error("pin driven while chip select high");
    chk_update_pulse: assert property (
        @(posedge ref_clk) disable iff (rst)
        config_update |=> !config_update)
        else $error("update pulse longer than one cycle");
endmodule

// *** testbench/host_model.sv ***
// Host model that drives the serial link of the control port
module host_model
(
    output logic sclk,
    output logic cs_n,
    output logic host_sdio,
    input wire logic sdio_out,
    input wire logic dedicated_readback_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lsb = 1'b0;
    logic sep = 1'b0;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        host_sdio = 1'b0;
    end

    // ====================
    // Link cycles
    // The clock stands low outside frames, as a real host leaves it
    task automatic open();
        cs_n <= 1'b0;
        #40;
    endtask

    task automatic close();
        #40 cs_n <= 1'b1;
        #80;
    endtask

    // A reading host lets go of the line, so a toggling value stands there
    task automatic word(input logic [15:0] w, input int n,
        input logic rd, output logic [15:0] q);
        int k;
        q = 16'h0000;
        for (int i = 0; i < n; i++) begin
            k = lsb ? i : n - 1 - i;
            host_sdio <= rd ? ~host_sdio : w[k];
            #40 sclk <= 1'b1;
            #1 q[k] = sep ? dedicated_readback_pin : sdio_out;
            #39 sclk <= 1'b0;
        end
    endtask
endmodule

// *** testbench/serial_control_port_slave_tb_top.sv ***
// Self-checking bench for the serial control port
module serial_control_port_slave_tb_top
    import serial_port_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk;
    logic rst;
    logic sclk;
    logic cs_n;
    logic host_sdio;
    logic sdio_in;
    logic sdio_out;
    logic sdio_oe;
    logic dedicated_readback_pin;
    logic readback_oe;
    logic frame_active;
    logic config_update;
    logic lsb_first_mode;
    logic separate_readback_mode;
    logic [1:0] seen = 2'h0;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    int pulses = 0;

    // ====================
    // Design, host and shared line
    assign sdio_in = sdio_oe ? sdio_out : host_sdio;

    serial_control_port u_dut (
        .ref_clk(ref_clk),
        .rst(rst),
        .sclk(sclk),
        .cs_n(cs_n),
        .sdio_in(sdio_in),
        .sdio_out(sdio_out),
        .sdio_oe(sdio_oe),
        .dedicated_readback_pin(dedicated_readback_pin),
        .readback_oe(readback_oe),
        .frame_active(frame_active),
        .config_update(config_update),
        .lsb_first_mode(lsb_first_mode),
        .separate_readback_mode(separate_readback_mode)
    );

    host_model u_host (
        .sclk(sclk),
        .cs_n(cs_n),
        .host_sdio(host_sdio),
        .sdio_out(sdio_out),
        .dedicated_readback_pin(dedicated_readback_pin)
    );

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Cleared as each frame opens; read frames in this bench never stall
    always @(posedge sclk or negedge cs_n) begin
        if (!sclk) begin
            seen <= 2'h0;
        end else if (!cs_n) begin
            seen <= seen | {readback_oe, sdio_oe};
        end
    end

    // Counting pulses also catches a pulse longer than one cycle
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (config_update === 1'b1) begin
            pulses++;
        end
        if (cycles == 5000) begin
            fails++;
            conclude();
        end
    end

    // ====================
    // Checks and transfers
    task automatic conclude();
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic instr(input logic rd, input logic [1:0] len,
        input logic [9:0] a);
        logic [15:0] q;
        u_host.open();
        u_host.word({rd, len, 3'h0, a}, 16, 1'b0, q);
    endtask

    task automatic wbyte(input logic [7:0] d);
        logic [15:0] q;
        u_host.word({8'h00, d}, 8, 1'b0, q);
    endtask

    task automatic rbyte(input logic [7:0] d);
        logic [15:0] q;
        u_host.word(16'h0000, 8, 1'b1, q);
        check("read data", d, q[7:0]);
    endtask

    task automatic fin(input logic full, input logic rd);
        if (full) begin
            check("active", 8'h01, {7'h00, frame_active});
        end
        u_host.close();
        check("pins", 8'h00, {6'h00, sdio_oe, readback_oe});
        if (rd) begin
            check("oe", {6'h00, u_host.sep, ~u_host.sep},
                {6'h00, seen});
        end
        repeat (5) @(posedge ref_clk);
        if (full) begin
            check("idle", 8'h00, {7'h00, frame_active});
        end
    endtask

    task automatic wr1(input logic [9:0] a, input logic [7:0] d);
        instr(1'b0, 2'h0, a);
        wbyte(d);
        fin(1'b1, 1'b0);
    endtask

    task automatic rd1(input logic [9:0] a, input logic [7:0] d);
        instr(1'b1, 2'h0, a);
        rbyte(d);
        fin(1'b1, 1'b1);
    endtask

    // ====================
    // Scenarios
    initial begin
        logic [15:0] q;
        rst = 1'b1;
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check("modes", 8'h00,
            {6'h00, lsb_first_mode, separate_readback_mode});
        rd1(CONFIG_ADDR, CONFIG_RESET);
        wr1(10'h00F, 8'h44);
        instr(1'b0, 2'h2, 10'h012);
        fin(1'b0, 1'b0);
        u_host.open();
        wbyte(8'hA1);
        fin(1'b0, 1'b0);
        u_host.open();
        wbyte(8'hB2);
        wbyte(8'hC3);
        wbyte(8'hEE);
        fin(1'b1, 1'b0);
        instr(1'b1, 2'h1, 10'h010);
        rbyte(8'hC3);
        rbyte(8'h44);
        fin(1'b1, 1'b1);
        instr(1'b1, 2'h2, 10'h012);
        rbyte(8'hA1);
        rbyte(8'hB2);
        rbyte(8'hC3);
        fin(1'b1, 1'b1);
        // Shadow and active banks
        wr1(READSEL_ADDR, 8'h01);
        check("no update", 8'h00, pulses[7:0]);
        wr1(UPDATE_ADDR, 8'h01);
        check("update", 8'h01, pulses[7:0]);
        rd1(10'h012, 8'hA1);
        wr1(10'h012, 8'h5C);
        rd1(10'h012, 8'hA1);
        wr1(READSEL_ADDR, 8'h00);
        rd1(10'h012, 8'h5C);
        rd1(UPDATE_ADDR, 8'h00);
        // Streams stop after the top register
        instr(1'b0, 2'h3, 10'h001);
        wbyte(8'h66);
        wbyte(8'h18);
        wbyte(8'h00);
        wbyte(8'h99);
        fin(1'b1, 1'b0);
        check("update", 8'h01, pulses[7:0]);
        instr(1'b1, 2'h3, 10'h001);
        rbyte(8'h66);
        rbyte(8'h18);
        rbyte(8'h00);
        fin(1'b1, 1'b1);
        // Aborts
        instr(1'b0, 2'h0, 10'h00F);
        u_host.word(16'h00FF, 5, 1'b0, q);
        fin(1'b0, 1'b0);
        instr(1'b0, 2'h1, 10'h00F);
        fin(1'b0, 1'b0);
        u_host.open();
        u_host.word(16'h0007, 3, 1'b0, q);
        fin(1'b0, 1'b0);
        rd1(10'h00F, 8'h44);
        // Separate pin, then least significant first
        wr1(CONFIG_ADDR, 8'h99);
        check("sep", 8'h01, {7'h00, separate_readback_mode});
        u_host.sep = 1'b1;
        rd1(10'h012, 8'h5C);
        wr1(CONFIG_ADDR, 8'h5A);
        u_host.sep = 1'b0;
        u_host.lsb = 1'b1;
        check("lsb", 8'h01, {7'h00, lsb_first_mode});
        instr(1'b0, 2'h1, 10'h011);
        wbyte(8'h3C);
        wbyte(8'h4D);
        fin(1'b1, 1'b0);
        instr(1'b1, 2'h2, 10'h010);
        rbyte(8'hC3);
        rbyte(8'h3C);
        rbyte(8'h4D);
        fin(1'b1, 1'b1);
        wr1(CONFIG_ADDR, 8'h18);
        u_host.lsb = 1'b0;
        rd1(10'h012, 8'h4D);
        conclude();
    end
endmodule
